// >>> hw/ctu_map.vh
// Register offsets, field positions, masks and reset values of the charge time unit control
`ifndef CTU_MAP_VH
`define CTU_MAP_VH
`define CTU_ADDR_W 4
`define CTU_OFS_CTRL_ONE 4'h0
`define CTU_OFS_SCAN_HIGH 4'h2
`define CTU_OFS_EDGE_STATUS 4'h4
`define CTU_OFS_STATUS 4'h6
`define CTU_REG_RESET 16'h0000
`define CTU_CTRL_ONE_MASK 16'hbf00
`define CTU_SCAN_HIGH_MASK 16'hc700
`define CTU_EDGE_STATUS_MASK 16'h0003
`define CTU_BIT_ENABLE 15
`define CTU_BIT_STOP_IDLE 13
`define CTU_BIT_TIME_GEN 12
`define CTU_BIT_HW_EDGE 11
`define CTU_BIT_EDGE_SEQ 10
`define CTU_BIT_DISCHARGE 9
`define CTU_BIT_CONV_TRIG 8
`define CTU_BIT_SCAN_CAP 15
`define CTU_BIT_SCAN_TEMP 14
`define CTU_BIT_SCAN_OA3 10
`define CTU_BIT_SCAN_OA2 9
`define CTU_BIT_SCAN_OA1 8
`define CTU_BIT_EDGE_ONE 0
`define CTU_BIT_EDGE_TWO 1
`define CTU_ST_RUNNING 0
`define CTU_ST_MEASURING 1
`define CTU_ST_DONE 2
`define CTU_SCAN_NONE 3'h0
`define CTU_SCAN_PRESENT 3'h1
`define CTU_SCAN_LOWREF 3'h2
`define CTU_SEL_PIN 1'b0
`define CTU_SEL_OPAMP 1'b1
`endif

// >>> hw/ctu_sync2.v
// Two flip-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/100ps
module ctu_sync2 #(
  parameter WIDTH = 4
) (
  input wire sys_clk,
  input wire resetn,
  input wire clkEn,
  input wire [WIDTH-1:0] asyncIn,
  output reg [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stageOne;

  // First stage feeds only the second stage
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stageOne <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end else if (clkEn) begin
      stageOne <= asyncIn;
      syncOut <= stageOne;
    end
  end
endmodule // ctu_sync2

// >>> hw/ctu_charge_time_unit.v
// Charge time unit control registers, edge logic and converter scan select
`timescale 1ns/100ps
`include "ctu_map.vh"
module ctu_charge_time_unit #(
  parameter CHAN_PRESENT = 5'h1f
) (
  input wire sys_clk,
  input wire resetn,
  input wire clkEn,
  input wire [`CTU_ADDR_W-1:0] regAddr,
  input wire [15:0] regWrData,
  input wire regWrStrobe,
  input wire regRdStrobe,
  output reg [15:0] regRdData,
  input wire deviceIdle,
  input wire [1:0] timerEdgeSource,
  input wire [1:0] externalEdgeInput,
  input wire [2:0] opampModeSelect,
  output wire unitActive,
  output wire timeGenerationOn,
  output wire currentSourceGround,
  output wire currentSourceOn,
  output reg convStartPulse,
  output wire [4:0] scanInclude,
  output wire [4:0] scanUseLowRef,
  output wire [2:0] opampRouteSel
);
  reg [15:0] chargeTimeControlOne;
  reg [15:0] converterScanSelectHigh;
  reg edgeOne;
  reg edgeTwo;
  reg measureDone;
  reg [1:0] prevHwEdge;
  wire [3:0] syncedEdges;
  wire [1:0] hwEdgeLevel;
  wire [1:0] hwEdgeRise;
  wire wrCtrl;
  wire wrScan;
  wire wrEdge;
  wire edgeOneEvent;
  wire edgeTwoEvent;
  reg next_edgeOne;
  reg next_edgeTwo;

  // Decodes a write strobe at a given offset
  function wrHit;
    input strobe;
    input [`CTU_ADDR_W-1:0] addr;
    input [`CTU_ADDR_W-1:0] ofs;
    begin
      wrHit = strobe & (addr == ofs);
    end
  endfunction

  // Hardware edge pins come from outside the clock domain
  ctu_sync2 #(
    .WIDTH(4)
  ) u_edgeSync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clkEn(clkEn),
    .asyncIn({externalEdgeInput, timerEdgeSource}),
    .syncOut(syncedEdges)
  );

  assign hwEdgeLevel = syncedEdges[3:2] | syncedEdges[1:0];
  assign hwEdgeRise = hwEdgeLevel & ~prevHwEdge;

  // Register write decode
  assign wrCtrl = wrHit(regWrStrobe, regAddr, `CTU_OFS_CTRL_ONE);
  assign wrScan = wrHit(regWrStrobe, regAddr, `CTU_OFS_SCAN_HIGH);
  assign wrEdge = wrHit(regWrStrobe, regAddr, `CTU_OFS_EDGE_STATUS);

  // Unit runs when enabled and not halted by idle
  assign unitActive = chargeTimeControlOne[`CTU_BIT_ENABLE] &
    ~(chargeTimeControlOne[`CTU_BIT_STOP_IDLE] & deviceIdle);
  assign timeGenerationOn = unitActive & chargeTimeControlOne[`CTU_BIT_TIME_GEN];
  assign currentSourceGround = chargeTimeControlOne[`CTU_BIT_DISCHARGE];

  // Edge events from hardware or from software status writes
  assign edgeOneEvent = chargeTimeControlOne[`CTU_BIT_HW_EDGE] ? hwEdgeRise[0] :
    (wrEdge & regWrData[`CTU_BIT_EDGE_ONE]);
  assign edgeTwoEvent = (chargeTimeControlOne[`CTU_BIT_HW_EDGE] ? hwEdgeRise[1] :
    (wrEdge & regWrData[`CTU_BIT_EDGE_TWO])) &
    (~chargeTimeControlOne[`CTU_BIT_EDGE_SEQ] | edgeOne | edgeOneEvent);

  // Current flows between edge one and edge two, never while grounded
  assign currentSourceOn = unitActive & edgeOne & ~edgeTwo & ~currentSourceGround;

  // Next edge status: events set while active, software write loads, set wins
  always @* begin
    next_edgeOne = edgeOne;
    next_edgeTwo = edgeTwo;
    if (wrEdge) begin
      next_edgeOne = regWrData[`CTU_BIT_EDGE_ONE];
      next_edgeTwo = regWrData[`CTU_BIT_EDGE_TWO];
    end
    if (!unitActive) begin
      next_edgeOne = wrEdge ? next_edgeOne : edgeOne;
      next_edgeTwo = wrEdge ? next_edgeTwo : edgeTwo;
    end else begin
      if (edgeOneEvent) begin
        next_edgeOne = 1'b1;
      end
      if (edgeTwoEvent) begin
        next_edgeTwo = 1'b1;
      end
    end
  end

  // Control and scan registers, edge state, trigger pulse
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      chargeTimeControlOne <= `CTU_REG_RESET;
      converterScanSelectHigh <= `CTU_REG_RESET;
      edgeOne <= 1'b0;
      edgeTwo <= 1'b0;
      prevHwEdge <= 2'h0;
      measureDone <= 1'b0;
      convStartPulse <= 1'b0;
    end else if (clkEn) begin
      prevHwEdge <= hwEdgeLevel;
      if (wrCtrl) begin
        chargeTimeControlOne <= regWrData & `CTU_CTRL_ONE_MASK;
      end
      if (wrScan) begin
        converterScanSelectHigh <= regWrData & `CTU_SCAN_HIGH_MASK;
      end
      edgeOne <= next_edgeOne;
      edgeTwo <= next_edgeTwo;
      measureDone <= next_edgeOne & next_edgeTwo;
      // Completion is the rise of both edges seen while active
      convStartPulse <= unitActive & chargeTimeControlOne[`CTU_BIT_CONV_TRIG] &
        ~measureDone & next_edgeOne & next_edgeTwo & ~(edgeOne & edgeTwo);
    end else begin
      convStartPulse <= 1'b0;
    end
  end

  // Scan selection per channel: cap, temp, op-amp three, two, one
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_scan
      wire selBit;
      if (gi == 0) begin : g_cap
        assign selBit = converterScanSelectHigh[`CTU_BIT_SCAN_CAP];
      end else if (gi == 1) begin : g_temp
        assign selBit = converterScanSelectHigh[`CTU_BIT_SCAN_TEMP];
      end else begin : g_oa
        assign selBit = converterScanSelectHigh[`CTU_BIT_SCAN_OA1 + 4 - gi];
      end
      assign scanInclude[gi] = selBit & CHAN_PRESENT[gi];
      assign scanUseLowRef[gi] = selBit & ~CHAN_PRESENT[gi];
    end
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_route
      assign opampRouteSel[gi] = opampModeSelect[gi] ? `CTU_SEL_OPAMP : `CTU_SEL_PIN;
    end
  endgenerate

  // Read data one cycle after the read strobe; unmapped reads zero
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      regRdData <= 16'h0000;
    end else if (clkEn) begin
      if (regRdStrobe) begin
        case (regAddr)
          `CTU_OFS_CTRL_ONE: regRdData <= chargeTimeControlOne;
          `CTU_OFS_SCAN_HIGH: regRdData <= converterScanSelectHigh;
          `CTU_OFS_EDGE_STATUS: regRdData <= {14'h0000, edgeTwo, edgeOne};
          `CTU_OFS_STATUS: regRdData <= {13'h0000, measureDone, currentSourceOn, unitActive};
          default: regRdData <= 16'h0000;
        endcase
      end else begin
        regRdData <= 16'h0000;
      end
    end
  end
endmodule // ctu_charge_time_unit

// >>> testbench/ctu_edge_src.sv
// Edge source model for the timer and external edge pins
`timescale 1ns/100ps
module ctu_edge_src (
  input wire sys_clk,
  input wire [1:0] fire,
  input wire viaExt,
  output reg [1:0] timerEdge = 2'h0,
  output reg [1:0] extEdge = 2'h0
);
  // Send each edge level down a timer line or an external pin
  always @(posedge sys_clk) begin
    timerEdge <= viaExt ? 2'h0 : fire;
    extEdge <= viaExt ? fire : 2'h0;
  end
endmodule // ctu_edge_src

// >>> testbench/ctu_chk.sv
// Port checker for the charge time unit control
`timescale 1ns/100ps
module ctu_chk (
  input wire sys_clk,
  input wire resetn,
  input wire [3:0] regAddr,
  input wire [15:0] regWrData,
  input wire regWrStrobe,
  input wire regRdStrobe,
  input wire [15:0] regRdData,
  input wire [2:0] opampModeSelect,
  input wire unitActive,
  input wire timeGenerationOn,
  input wire currentSourceGround,
  input wire currentSourceOn,
  input wire convStartPulse,
  input wire [4:0] scanInclude,
  input wire [4:0] scanUseLowRef,
  input wire [2:0] opampRouteSel
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Read data, readback masks, pulse width and output relations
  chk_read_quiet: assert property (!$past(regRdStrobe) |-> regRdData == 16'h0)
    else $error("read data outside slot");
  chk_ctrl_back: assert property (regWrStrobe && regAddr == 4'h0 ##1 regRdStrobe &&
    regAddr == 4'h0 |=> regRdData == ($past(regWrData, 2) & 16'hbf00)) else $error("ctrl");
  chk_scan_back: assert property (regWrStrobe && regAddr == 4'h2 ##1 regRdStrobe &&
    regAddr == 4'h2 |=> regRdData == ($past(regWrData, 2) & 16'hc700)) else $error("scan");
  chk_pulse_single: assert property (convStartPulse |=> !convStartPulse)
    else $error("long start pulse");
  chk_timegen_active: assert property (timeGenerationOn |-> unitActive)
    else $error("time generation while off");
  chk_ground_source: assert property (currentSourceGround |-> !currentSourceOn)
    else $error("source on while grounded");
  chk_route_mode: assert property (opampRouteSel == opampModeSelect)
    else $error("op-amp route");
  chk_lowref_excl: assert property ((scanInclude & scanUseLowRef) == 5'h0)
    else $error("low reference overlap");
endmodule // ctu_chk

// >>> testbench/ctu_charge_time_unit_test.sv
// Self-checking bench for the charge time unit control
`timescale 1ns/100ps
module ctu_charge_time_unit_test;
  logic sys_clk = 0, resetn = 0, regWrStrobe = 0, regRdStrobe = 0, deviceIdle = 0, viaExt = 0;
  logic clkEn = 1;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWrData = 16'h0, q, d, pulses = 0;
  logic [2:0] opampModeSelect = 3'h0;
  logic [1:0] fire = 2'h0;
  wire [15:0] regRdData;
  wire [1:0] timerEdge, extEdge;
  wire unitActive, timeGenerationOn, currentSourceGround, currentSourceOn, convStartPulse;
  wire [4:0] scanInclude, scanUseLowRef;
  wire [2:0] opampRouteSel;
  integer mismatches = 0, total_checks = 0, cycles = 0, i;
  always #5 sys_clk = ~sys_clk;
  ctu_charge_time_unit #(.CHAN_PRESENT(5'h1b)) dut_u (.sys_clk, .resetn, .clkEn,
    .regAddr, .regWrData, .regWrStrobe, .regRdStrobe, .regRdData, .deviceIdle,
    .timerEdgeSource(timerEdge), .externalEdgeInput(extEdge), .opampModeSelect,
    .unitActive, .timeGenerationOn, .currentSourceGround, .currentSourceOn,
    .convStartPulse, .scanInclude, .scanUseLowRef, .opampRouteSel);
  ctu_edge_src src_u (.sys_clk, .fire, .viaExt, .timerEdge, .extEdge);
  // Count start pulses and cut a hang short
  always @(posedge sys_clk) begin
    pulses <= pulses + convStartPulse;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches = mismatches + 1;
      complete_run;
    end
  end
  // Scan outputs expected from a scan word
  function [4:0] sel(input [15:0] v);
    sel = {v[8], v[9], v[10], v[14], v[15]};
  endfunction
  task chk(input [15:0] g, input [15:0] e);
    total_checks = total_checks + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task wr(input [3:0] a, input [15:0] v);
    regAddr <= a;
    regWrData <= v;
    regWrStrobe <= 1;
    @(posedge sys_clk);
    regWrStrobe <= 0;
    #1;
  endtask
  task rd(input [3:0] a, input [15:0] e);
    regAddr <= a;
    regRdStrobe <= 1;
    @(posedge sys_clk);
    regRdStrobe <= 0;
    @(negedge sys_clk);
    chk(regRdData, e);
    @(posedge sys_clk);
    #1;
  endtask
  task pulse(input [1:0] f);
    fire <= f;
    repeat (4) @(posedge sys_clk);
    fire <= 2'h0;
    repeat (6) @(posedge sys_clk);
    #1;
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    d = $urandom(81);
    repeat (5) @(posedge sys_clk);
    resetn <= 1;
    @(posedge sys_clk);
    #1;
    rd(4'h0, 16'h0);
    rd(4'h2, 16'h0);
    rd(4'he, 16'h0);
    for (i = 0; i < 20; i = i + 1) begin
      d = i == 0 ? 16'hffff : $urandom;
      opampModeSelect <= d[2:0];
      wr(4'h0, d);
      rd(4'h0, d & 16'hbf00);
      wr(4'h2, d ^ 16'h5a5a);
      rd(4'h2, (d ^ 16'h5a5a) & 16'hc700);
      chk(scanInclude, sel(d ^ 16'h5a5a) & 5'h1b);
      chk(scanUseLowRef, sel(d ^ 16'h5a5a) & 5'h04);
    end
    wr(4'h0, 16'h8000);
    chk(unitActive, 1);
    deviceIdle <= 1;
    wr(4'h0, 16'ha000);
    chk(unitActive, 0);
    wr(4'h0, 16'h9000);
    chk(timeGenerationOn, 1);
    deviceIdle <= 0;
    wr(4'h0, 16'h1200);
    chk({unitActive, timeGenerationOn, currentSourceGround}, 1);
    wr(4'h0, 16'h8d00);
    wr(4'h4, 16'h0);
    pulse(2'h2);
    rd(4'h4, 16'h0);
    pulse(2'h1);
    chk(currentSourceOn, 1);
    rd(4'h6, 16'h3);
    viaExt <= 1;
    d = pulses;
    pulse(2'h2);
    chk(pulses, d + 1);
    rd(4'h4, 16'h3);
    wr(4'h0, 16'h8100);
    wr(4'h4, 16'h0);
    pulse(2'h3);
    rd(4'h4, 16'h0);
    wr(4'h4, 16'h3);
    wr(4'h0, 16'h8000);
    wr(4'h4, 16'h0);
    wr(4'h4, 16'h3);
    pulse(2'h0);
    chk(pulses, d + 2);
    // A write while the clock enable is low must leave the control register alone
    clkEn <= 0;
    wr(4'h0, 16'h0000);
    clkEn <= 1;
    chk(unitActive, 1);
    @(posedge sys_clk);
    #1;
    rd(4'h0, 16'h8000);
    complete_run;
  end
endmodule // ctu_charge_time_unit_test
bind ctu_charge_time_unit ctu_chk chk_u (.sys_clk, .resetn, .regAddr, .regWrData,
  .regWrStrobe, .regRdStrobe, .regRdData, .opampModeSelect, .unitActive, .timeGenerationOn,
  .currentSourceGround, .currentSourceOn, .convStartPulse, .scanInclude, .scanUseLowRef,
  .opampRouteSel);
